// [src/pin_change_irq.sv]
/*
 Pin-change groups and external-line flags with their registers.
 Assumes the core gives one-cycle read/write strobes, samples RDATA one
 cycle after RD_EN, and pulses an acknowledge on vector entry.
*/
`timescale 1ns/10ps
`default_nettype none

module pin_change_irq
   import pin_irq_pkg::*;
#(
   parameter int GROUP_COUNT = GROUPS
)
(
   // Clock and reset
   input  wire logic                     MCLK,
   input  wire logic                     RESET_N,
   // Core register access
   input  wire logic [7:0]               ADDR,
   input  wire logic                     IO_SPACE,
   input  wire logic                     WR_EN,
   input  wire logic                     RD_EN,
   input  wire logic [7:0]               WDATA,
   output logic      [7:0]               RDATA,
   // Settings held elsewhere in the core
   input  wire logic                     GLOBAL_IE,
   input  wire logic [LINES-1:0]         LINE_ENABLE,
   input  wire logic [1:0]               LINE0_SENSE_FIELD,
   input  wire logic [1:0]               LINE1_SENSE_FIELD,
   // Pins
   input  wire logic [LINES-1:0]         EXT_LINE_IN,
   input  wire logic [GROUPS*GROUP_BITS-1:0] CHANGE_WATCH_IN,
   // Vector requests and acknowledges
   output logic      [LINES-1:0]         LINE_REQ,
   input  wire logic [LINES-1:0]         LINE_ACK,
   output logic      [GROUPS-1:0]        GROUP_REQ,
   input  wire logic [GROUPS-1:0]        GROUP_ACK
);

   if (GROUP_COUNT != GROUPS)
   begin : g_bad_count
      $error("pin_change_irq: group count is fixed by the register map");
   end

   // Address decode
   function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
      reg_hit = (addr == off);
   endfunction

   // Edge-mode event from sense code; level mode never sets a flag
   function automatic logic line_event(input sense_t s, input logic cur, input logic prev);
      case (s)
         SENSE_ANY:  line_event = cur ^ prev;
         SENSE_FALL: line_event = prev & ~cur;
         SENSE_RISE: line_event = cur & ~prev;
         default:    line_event = 1'b0;
      endcase
   endfunction

   logic [7:0]        eff_addr;
   logic              hit_gflag;
   logic              hit_lflag;
   logic              hit_gen;
   logic [GROUPS-1:0] hit_mask;
   logic              wr_gflag;
   logic              wr_lflag;
   logic              wr_gen;

   logic [GROUPS-1:0] gflag_q;
   logic [GROUPS-1:0] gflag_d;
   logic [GROUPS-1:0] gen_q;
   logic [GROUPS-1:0] gen_d;
   logic [7:0]        mask_q [GROUPS];
   logic [GROUPS-1:0] group_set;

   logic [LINES-1:0]  lflag_q;
   logic [LINES-1:0]  lflag_d;
   logic [LINES-1:0]  line_samp_q;
   logic [LINES-1:0]  line_prev_q;
   logic [1:0]        line_armed_q;
   logic [LINES-1:0]  line_set;
   logic [LINES-1:0]  line_level;
   sense_t            line_sense [LINES];

   logic [7:0]        rd_data_d;
   logic [7:0]        mask_rd [GROUPS];

   // Short form only spans 0x20..0x5F, so extended registers stay unreachable
   assign eff_addr = IO_SPACE ? 8'({2'b00, ADDR[IO_ADDR_W-1:0]} + IO_BASE)
                              : ADDR;
   assign hit_gflag = reg_hit(eff_addr, OFF_GROUP_FLAG);
   assign hit_lflag = reg_hit(eff_addr, OFF_LINE_FLAG);
   assign hit_gen   = reg_hit(eff_addr, OFF_GROUP_EN);
   assign wr_gflag  = WR_EN & hit_gflag;
   assign wr_lflag  = WR_EN & hit_lflag;
   assign wr_gen    = WR_EN & hit_gen;

   // Pin-change groups
   group_watch_if #(.WIDTH(GROUP_BITS)) gw [GROUPS] ();

   for (genvar g = 0; g < GROUPS; g++)
   begin : g_group
      assign hit_mask[g]  = reg_hit(eff_addr, OFF_MASK[g]);
      assign gw[g].pins   = CHANGE_WATCH_IN[g*GROUP_BITS +: GROUP_BITS];
      assign gw[g].mask   = mask_q[g];
      assign group_set[g] = gw[g].change;
      assign mask_rd[g]   = hit_mask[g] ? mask_q[g] : REG_RESET;

      change_watch_group #(.WIDTH(GROUP_BITS)) u_watch
      (
         .MCLK    (MCLK),
         .RESET_N (RESET_N),
         .grp     (gw[g])
      );

      always_ff @(posedge MCLK)
      begin
         if (!RESET_N)
            mask_q[g] <= REG_RESET;
         else if (WR_EN && hit_mask[g])
            mask_q[g] <= WDATA;
      end
   end

   // Set beats acknowledge and write-one clear; enables do not gate setting
   assign gflag_d = group_set | (gflag_q & ~(GROUP_ACK
                    | ({GROUPS{wr_gflag}} & WDATA[GROUPS-1:0])));
   assign gen_d   = wr_gen ? WDATA[GROUPS-1:0] : gen_q;
   // One request line per group, each its own vector
   assign GROUP_REQ = gflag_q & gen_q & {GROUPS{GLOBAL_IE}};

   // External lines; pin direction is not seen here, so outputs still trigger
   assign line_sense[0] = sense_t'(LINE0_SENSE_FIELD);
   assign line_sense[1] = sense_t'(LINE1_SENSE_FIELD);

   for (genvar l = 0; l < LINES; l++)
   begin : g_line
      assign line_level[l] = (line_sense[l] == SENSE_LOW);
      assign line_set[l]   = line_armed_q[1]
                             & line_event(line_sense[l], line_samp_q[l], line_prev_q[l]);
      // Level mode pins the flag low; set wins over both clears otherwise
      assign lflag_d[l] = line_level[l] ? 1'b0
                          : line_set[l] | (lflag_q[l] & ~(LINE_ACK[l]
                            | (wr_lflag & WDATA[l])));
      // Level request follows the pin itself, never a stored flag
      assign LINE_REQ[l] = GLOBAL_IE & LINE_ENABLE[l]
                           & (line_level[l] ? ~line_samp_q[l] : lflag_q[l]);
   end

   // Read data
   always_comb
   begin
      rd_data_d = REG_RESET;
      if (hit_gflag)
         rd_data_d = {{(8-GROUPS){1'b0}}, gflag_q};
      else if (hit_lflag)
         rd_data_d = {{(8-LINES){1'b0}}, lflag_q};
      else if (hit_gen)
         rd_data_d = {{(8-GROUPS){1'b0}}, gen_q};
      else
         for (int k = 0; k < GROUPS; k++)
            rd_data_d = rd_data_d | mask_rd[k];
   end

   always_ff @(posedge MCLK)
   begin
      if (!RESET_N)
      begin
         gflag_q <= '0;
         gen_q   <= '0;
         lflag_q <= '0;
      end
      else
      begin
         gflag_q <= gflag_d;
         gen_q   <= gen_d;
         lflag_q <= lflag_d;
      end
   end

   always_ff @(posedge MCLK)
   begin
      if (!RESET_N)
      begin
         line_samp_q  <= '0;
         line_prev_q  <= '0;
         line_armed_q <= '0;
      end
      else
      begin
         line_samp_q  <= EXT_LINE_IN;
         line_prev_q  <= line_samp_q;
         line_armed_q <= {line_armed_q[0], 1'b1};
      end
   end

   // Unmapped reads return zero; RDATA holds its last value while RD_EN is low
   always_ff @(posedge MCLK)
   begin
      if (!RESET_N)
         RDATA <= REG_RESET;
      else if (RD_EN)
         RDATA <= rd_data_d;
   end

   // Checks
   line_flag_set_a : assert property (
      @(posedge MCLK) disable iff (!RESET_N)
      (line_set[1] && !line_level[1]) |=> lflag_q[1])
      else $error("line 1 event did not set its flag");

   line_req_a : assert property (
      @(posedge MCLK) disable iff (!RESET_N)
      (LINE_REQ[0] && !line_level[0]) |-> (lflag_q[0] && GLOBAL_IE && LINE_ENABLE[0]))
      else $error("line 0 request without flag and enables");

   ack_clear_a : assert property (
      @(posedge MCLK) disable iff (!RESET_N)
      (GROUP_ACK[2] && !group_set[2]) |=> !gflag_q[2])
      else $error("group 2 flag survived its acknowledge");

   w1c_a : assert property (
      @(posedge MCLK) disable iff (!RESET_N)
      (wr_gflag && !GROUP_ACK[0] && !group_set[0])
      |=> (gflag_q[0] == ($past(gflag_q[0]) && !$past(WDATA[0]))))
      else $error("group 0 flag write-one-clear wrong");

   level_zero_a : assert property (
      @(posedge MCLK) disable iff (!RESET_N)
      line_level[0] |=> !lflag_q[0])
      else $error("line 0 flag set in level mode");

   sense_rise_a : assert property (
      @(posedge MCLK) disable iff (!RESET_N)
      (line_armed_q[1] && line_sense[0] == SENSE_RISE && line_samp_q[0]
       && !line_prev_q[0]) |=> lflag_q[0])
      else $error("rising edge on line 0 missed");

   group_en_a : assert property (
      @(posedge MCLK) disable iff (!RESET_N)
      GROUP_REQ[1] |-> (GLOBAL_IE && gen_q[1] && gflag_q[1]))
      else $error("group 1 request without enables");

   pin_map_a : assert property (
      @(posedge MCLK) disable iff (!RESET_N)
      (mask_q[1][1] && $changed(CHANGE_WATCH_IN[9]) && !GROUP_ACK[1] && !wr_gflag)
      ##1 (mask_q[1][1] && $stable(CHANGE_WATCH_IN[9])) ##1 mask_q[1][1]
      |=> gflag_q[1])
      else $error("pin 9 change did not reach group 1");

   group_req_a : assert property (
      @(posedge MCLK) disable iff (!RESET_N)
      (gflag_q[3] && gen_q[3] && GLOBAL_IE) |-> GROUP_REQ[3])
      else $error("group 3 request missing");

   mask_block_a : assert property (
      @(posedge MCLK) disable iff (!RESET_N)
      (mask_q[0] == REG_RESET && !gflag_q[0])[*3] |=> !gflag_q[0])
      else $error("group 0 flag set with all pins masked");

   io_flag_a : assert property (
      @(posedge MCLK) disable iff (!RESET_N)
      (RD_EN && IO_SPACE && ADDR[IO_ADDR_W-1:0] == 6'h1B)
      |=> (RDATA == {4'h0, $past(gflag_q)}))
      else $error("short-form read of group flags wrong");

   poll_a : assert property (
      @(posedge MCLK) disable iff (!RESET_N)
      (group_set[0] && !GLOBAL_IE) |=> gflag_q[0])
      else $error("group 0 flag not set while disabled");

   line_ack_a : assert property (
      @(posedge MCLK) disable iff (!RESET_N)
      (LINE_ACK[0] && !line_set[0]) |=> !lflag_q[0])
      else $error("line 0 flag survived its acknowledge");

   line_w1c_a : assert property (
      @(posedge MCLK) disable iff (!RESET_N)
      (wr_lflag && WDATA[1] && !line_set[1]) |=> !lflag_q[1])
      else $error("line 1 flag not cleared by write of one");

   line_keep_a : assert property (
      @(posedge MCLK) disable iff (!RESET_N)
      (lflag_q[1] && wr_lflag && !WDATA[1] && !LINE_ACK[1] && !line_level[1])
      |=> lflag_q[1])
      else $error("line 1 flag lost on write of zero");

   line_any_a : assert property (
      @(posedge MCLK) disable iff (!RESET_N)
      (line_armed_q[1] && line_sense[1] == SENSE_ANY
       && line_samp_q[1] != line_prev_q[1]) |=> lflag_q[1])
      else $error("line 1 change missed");

   vector_own_a : assert property (
      @(posedge MCLK) disable iff (!RESET_N)
      (GROUP_REQ[0] && !gflag_q[2]) |-> !GROUP_REQ[2])
      else $error("group 2 vector raised by another group");

   group_set_a : assert property (
      @(posedge MCLK) disable iff (!RESET_N)
      group_set[2] |=> gflag_q[2])
      else $error("group 2 change did not set its flag");

   mask1_gate_a : assert property (
      @(posedge MCLK) disable iff (!RESET_N)
      (mask_q[1] == REG_RESET) |-> !group_set[1])
      else $error("group 1 change seen with mask clear");

   mask2_gate_a : assert property (
      @(posedge MCLK) disable iff (!RESET_N)
      (mask_q[2] == REG_RESET) |-> !group_set[2])
      else $error("group 2 change seen with mask clear");

   mask3_gate_a : assert property (
      @(posedge MCLK) disable iff (!RESET_N)
      (mask_q[3] == REG_RESET) |-> !group_set[3])
      else $error("group 3 change seen with mask clear");

   io_write_a : assert property (
      @(posedge MCLK) disable iff (!RESET_N)
      (WR_EN && IO_SPACE && ADDR[IO_ADDR_W-1:0] == 6'h1B && WDATA[1] && !group_set[1])
      |=> !gflag_q[1])
      else $error("short-form write did not clear group 1 flag");

   group_irq_c : cover property (
      @(posedge MCLK) disable iff (!RESET_N)
      GROUP_REQ[0] ##1 GROUP_ACK[0]);

   line_irq_c : cover property (
      @(posedge MCLK) disable iff (!RESET_N)
      (LINE_REQ[1] && !line_level[1]) ##[1:20] LINE_ACK[1]);

   sw_clear_c : cover property (
      @(posedge MCLK) disable iff (!RESET_N)
      gflag_q[3] ##1 (wr_gflag && WDATA[3]) ##1 !gflag_q[3]);

   level_req_c : cover property (
      @(posedge MCLK) disable iff (!RESET_N)
      LINE_REQ[0] && line_level[0]);

   poll_c : cover property (
      @(posedge MCLK) disable iff (!RESET_N)
      group_set[0] && !GLOBAL_IE);

endmodule

`default_nettype wire

// [src/pin_irq_pkg.sv]
/*
 Constants, register map and sense encodings for the pin-change and
 external-line flag block. Assumes one system clock and a core that
 reaches the registers by data-space or short-form port addresses.
*/
package pin_irq_pkg;

   localparam int GROUPS      = 4;
   localparam int GROUP_BITS  = 8;
   localparam int LINES       = 2;
   localparam int IO_ADDR_W   = 6;

   localparam logic [7:0] REG_RESET      = 8'h00;
   localparam logic [7:0] IO_BASE        = 8'h20;
   localparam logic [7:0] OFF_GROUP_FLAG = 8'h3B;
   localparam logic [7:0] OFF_LINE_FLAG  = 8'h3C;
   localparam logic [7:0] OFF_GROUP_EN   = 8'h68;
   localparam logic [7:0] OFF_MASK [GROUPS] = '{8'h6B, 8'h6C, 8'h6D, 8'h73};

   typedef enum logic [1:0]
   {
      SENSE_LOW  = 2'b00,
      SENSE_ANY  = 2'b01,
      SENSE_FALL = 2'b10,
      SENSE_RISE = 2'b11
   } sense_t;

endpackage

// [src/group_watch_if.sv]
/*
 Carrier between the register block and one pin-change group detector.
 Assumes both ends run on the same system clock.
*/
`timescale 1ns/10ps
`default_nettype none

interface group_watch_if
#(
   parameter int WIDTH = 8
);
   logic [WIDTH-1:0] pins;
   logic [WIDTH-1:0] mask;
   logic             change;

   modport detector
   (
      input  pins,
      input  mask,
      output change
   );

   modport owner
   (
      output pins,
      output mask,
      input  change
   );
endinterface

`default_nettype wire

// [src/change_watch_group.sv]
/*
 Change detector for one group of eight watched pins.
 Assumes pins already synchronous to MCLK.
*/
`timescale 1ns/10ps
`default_nettype none

module change_watch_group
   import pin_irq_pkg::*;
#(
   parameter int WIDTH = GROUP_BITS
)
(
   // Clock and reset
   input  wire logic        MCLK,
   input  wire logic        RESET_N,
   // Group signals
   group_watch_if.detector  grp
);

   logic [WIDTH-1:0] sample_q;
   logic [WIDTH-1:0] prev_q;
   logic [1:0]       armed_q;
   logic [WIDTH-1:0] diff;

   if (WIDTH != GROUP_BITS)
   begin : g_bad_width
      $error("change_watch_group: width must match the register width");
   end

   always_ff @(posedge MCLK)
   begin
      if (!RESET_N)
      begin
         sample_q <= '0;
         prev_q   <= '0;
         armed_q  <= '0;
      end
      else
      begin
         sample_q <= grp.pins;
         prev_q   <= sample_q;
         armed_q  <= {armed_q[0], 1'b1};
      end
   end

   // No compare until both samples hold real pin values
   assign diff       = (sample_q ^ prev_q) & grp.mask;
   assign grp.change = armed_q[1] & (|diff);

   // Judged from the pin itself, so a broken diff path still trips it
   masked_change_a : assert property (
      @(posedge MCLK) disable iff (!RESET_N)
      (armed_q[1] && grp.pins[0] != sample_q[0]) |=> (!grp.mask[0] || grp.change))
      else $error("masked pin change not reported");

endmodule

`default_nettype wire

// [testbench/core_partner.sv]
/*
 Core-side vectoring model: acknowledges the lowest pending request
 after a chosen wait, one-cycle pulse. Assumes requests are levels.
*/
`timescale 1ns/10ps
`default_nettype none

module core_partner
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Control from bench
   input  wire logic       auto,
   input  wire logic [3:0] wait_n,
   // Requests and acknowledges
   input  wire logic [5:0] req,
   output logic      [5:0] ack
);
   logic [3:0] cnt_q;
   wire        due = (cnt_q == wait_n);

   // Distinct ack per vector; lowest index served first
   always_ff @(posedge clk)
   begin
      if (!rst_n || !auto || req == 6'h00 || ack != 6'h00)
      begin
         ack   <= 6'h00;
         cnt_q <= 4'h0;
      end
      else
      begin
         ack   <= due ? (req & (~req + 6'h01)) : 6'h00;
         cnt_q <= due ? 4'h0 : cnt_q + 4'h1;
      end
   end
endmodule

`default_nettype wire

// [testbench/pin_change_and_ext_irq_flags_tb.sv]
/*
 Self-checking bench for the pin-change and line flag block.
 Assumes the core access protocol of one-cycle strobes, RDATA next cycle.
*/
`timescale 1ns/10ps
`default_nettype none

module pin_change_and_ext_irq_flags_tb
   import pin_irq_pkg::*;
;
   logic        mclk = 0, reset_n = 0, io = 0, wr = 0, rd = 0, gie = 0, auto = 0;
   logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
   logic [1:0]  len = 2'b00, s0 = 2'b00, s1 = 2'b00, ext = 2'b01, lreq, lack;
   logic [31:0] pins = 32'h0000_0000;
   logic [3:0]  greq, gack, wait_n = 4'h0;
   logic [7:0]  regs [7] = '{8'h3B, 8'h3C, 8'h68, 8'h6B, 8'h6C, 8'h6D, 8'h73};
   int          n_fail = 0, compares = 0, cyc = 0;

   pin_change_irq uut (.MCLK(mclk), .RESET_N(reset_n), .ADDR(addr), .IO_SPACE(io),
      .WR_EN(wr), .RD_EN(rd), .WDATA(wdata), .RDATA(rdata), .GLOBAL_IE(gie),
      .LINE_ENABLE(len), .LINE0_SENSE_FIELD(s0), .LINE1_SENSE_FIELD(s1),
      .EXT_LINE_IN(ext), .CHANGE_WATCH_IN(pins), .LINE_REQ(lreq), .LINE_ACK(lack),
      .GROUP_REQ(greq), .GROUP_ACK(gack));

   core_partner core (.clk(mclk), .rst_n(reset_n), .auto(auto), .wait_n(wait_n),
      .req({greq, lreq}), .ack({gack, lack}));

   always #4 mclk = ~mclk;

   // Whole run needs well under 1000 cycles
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_fail++;
         conclude();
      end
   end

   task automatic conclude();
      $display("Compares %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic waitc(input int n);
      repeat (n) @(posedge mclk);
   endtask

   task automatic wrr(input logic [7:0] a, input logic i, input logic [7:0] d);
      @(posedge mclk);
      addr  <= a;
      io    <= i;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge mclk);
      wr    <= 1'b0;
   endtask

   task automatic rdc(input logic [7:0] a, input logic i, input logic [7:0] e);
      @(posedge mclk);
      addr <= a;
      io   <= i;
      rd   <= 1'b1;
      @(posedge mclk);
      rd   <= 1'b0;
      #1 chk(rdata, e);
   endtask

   // Toggle one watched pin, then allow the two-edge detection latency
   task automatic tog(input int b);
      @(posedge mclk);
      pins[b] <= ~pins[b];
      waitc(3);
   endtask

   initial
   begin
      waitc(5);
      reset_n <= 1'b1;
      waitc(2);
      for (int k = 0; k < 7; k++)
         rdc(regs[k], 1'b0, 8'h00);
      for (int k = 3; k < 7; k++)
      begin
         wrr(regs[k], 1'b0, 8'h02);
         rdc(regs[k], 1'b0, 8'h02);
      end
      wrr(8'h68, 1'b0, 8'hFF);
      rdc(8'h68, 1'b0, 8'h0F);
      rdc(8'h70, 1'b0, 8'h00);
      for (int g = 0; g < 4; g++)
      begin
         // Group 0 runs with interrupts off: flag only, no request
         @(posedge mclk) gie <= (g != 0);
         tog(8 * g);
         rdc(8'h1B, 1'b1, 8'h00);
         tog(8 * g + 1);
         rdc(8'h1B, 1'b1, 8'h01 << g);
         chk({4'h0, greq}, (g != 0) ? (8'h01 << g) : 8'h00);
         wrr(8'h3B, 1'b0, 8'h00);
         rdc(8'h3B, 1'b0, 8'h01 << g);
         wrr(8'h3B, 1'b0, 8'h01 << g);
         rdc(8'h3B, 1'b0, 8'h00);
      end
      @(posedge mclk) auto <= 1'b1;
      tog(25);
      waitc(6);
      rdc(8'h3B, 1'b0, 8'h00);
      chk({4'h0, greq}, 8'h00);
      @(posedge mclk) auto <= 1'b0;
      len <= 2'b11;
      for (int s = 1; s < 4; s++)
      begin
         @(posedge mclk) s1 <= s[1:0];
         wrr(8'h3C, 1'b0, 8'h03);
         @(posedge mclk) ext[1] <= 1'b1;
         waitc(3);
         rdc(8'h1C, 1'b1, {6'h00, s != 2, 1'b0});
         chk({6'h00, lreq}, {6'h00, s != 2, 1'b0});
         wrr(8'h3C, 1'b0, 8'h02);
         @(posedge mclk) ext[1] <= 1'b0;
         waitc(3);
         rdc(8'h1C, 1'b1, {6'h00, s != 3, 1'b0});
         wrr(8'h3C, 1'b0, 8'h02);
         rdc(8'h3C, 1'b0, 8'h00);
      end
      @(posedge mclk) ext[0] <= 1'b0;
      waitc(3);
      rdc(8'h1C, 1'b1, 8'h00);
      chk({6'h00, lreq}, 8'h01);
      @(posedge mclk) ext[0] <= 1'b1;
      waitc(3);
      chk({6'h00, lreq}, 8'h00);
      // Slow acknowledge this time
      @(posedge mclk) s1 <= 2'b01;
      wait_n <= 4'h5;
      auto   <= 1'b1;
      ext[1] <= 1'b1;
      waitc(14);
      rdc(8'h1C, 1'b1, 8'h00);
      chk({6'h00, lreq}, 8'h00);
      conclude();
   end
endmodule

`default_nettype wire
